// [rrec_pkg.sv]
// Purpose: shared constants for the receive-side error check block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   offsets are byte addresses, reset values and timing are here
package rrec_pkg;

  // register byte offsets
  localparam logic [7:0] RREC_OFF_CTRL   = 8'h00;  // mode, fec, diversity
  localparam logic [7:0] RREC_OFF_THRESH = 8'h04;  // strength threshold, dbm
  localparam logic [7:0] RREC_OFF_RSSI   = 8'h08;  // strength query answer
  localparam logic [7:0] RREC_OFF_STAT   = 8'h0C;  // sticky events, w1c
  localparam logic [7:0] RREC_OFF_MASK   = 8'h10;  // interrupt mask
  localparam logic [7:0] RREC_OFF_LIVE   = 8'h14;  // live strength and state

  // control field positions
  localparam int RREC_CTRL_MODE_LSB = 0;           // two-bit check mode
  localparam int RREC_CTRL_FEC      = 2;           // forward correction on
  localparam int RREC_CTRL_DIV      = 3;           // second receiver in use

  // reset values
  localparam logic [1:0] RREC_RST_MODE   = 2'h0;   // no-check after reset
  localparam logic       RREC_RST_FEC    = 1'b0;
  localparam logic       RREC_RST_DIV    = 1'b0;
  localparam logic [7:0] RREC_RST_THRESH = 8'h92;  // -110 dbm
  localparam logic [4:0] RREC_RST_MASK   = 5'h00;

  // status bit positions
  localparam int RREC_ST_OK   = 0;                 // message delivered
  localparam int RREC_ST_ERR  = 1;                 // checksum failure
  localparam int RREC_ST_FIX  = 2;                 // bit corrected
  localparam int RREC_ST_EXP  = 3;                 // held strength expired
  localparam int RREC_ST_OVF  = 4;                 // full-mode overflow
  localparam int RREC_ST_W    = 5;

  // checksum: crc-16, x^16+x^12+x^5+1
  localparam logic [15:0] RREC_CRC_POLY = 16'h1021;
  localparam logic [15:0] RREC_CRC_INIT = 16'hFFFF;

  // code layout: 16 data bits plus 5 parity bits
  localparam int RREC_DATA_W = 16;
  localparam int RREC_CODE_W = 21;

  // timing
  localparam int RREC_CLK_HZ   = 25_000_000;
  localparam int RREC_HOLD_S   = 7;                // strength hold, seconds
  localparam int RREC_HOLD_CYC = RREC_HOLD_S * RREC_CLK_HZ;

  // check modes
  typedef enum logic [1:0] {
    RREC_CHK_NONE = 2'h0,
    RREC_CHK_PART = 2'h1,
    RREC_CHK_FULL = 2'h2
  } rrec_mode_t;

  // transmit sequencer, one-hot
  typedef enum logic [1:0] {
    RREC_TX_DATA = 2'b01,
    RREC_TX_CK   = 2'b10
  } rrec_tx_t;

endpackage

// [rrec_top.sv]
// Purpose: fec encode/decode, sub-frame checksums, check modes, strength hold
// Assumes: code words arrive one per cycle; apb answers on second access cycle
// Notes:   terminal side has no back-pressure; buffer absorbs rate changes
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module rrec_top #(
  parameter int SUB_WORDS = 4,                      // data words per sub-frame
  parameter int DEPTH     = 256,                    // receive buffer words
  parameter int HOLD_CYC  = rrec_pkg::RREC_HOLD_CYC // strength hold, cycles
) (
  input  wire logic                             ref_clk_i,
  input  wire logic                             rst_i,
  // apb slave
  input  wire logic                             psel_i,
  input  wire logic                             penable_i,
  input  wire logic                             pwrite_i,
  input  wire logic [7:0]                       paddr_i,
  input  wire logic [31:0]                      pwdata_i,
  output logic                                  pready_o,
  output logic [31:0]                           prdata_o,
  output logic                                  pslverr_o,
  output logic                                  irq_o,
  // radio front end
  input  wire logic                             rx_state_i,
  input  wire logic [7:0]                       rssi_a_i,
  input  wire logic [7:0]                       rssi_b_i,
  output logic                                  search_en_o,
  output logic                                  rx_sel_o,
  input  wire logic                             rx_valid_i,
  input  wire logic                             rx_last_i,
  input  wire logic [rrec_pkg::RREC_CODE_W-1:0] rx_code_i,
  output logic                                  rx_ready_o,
  // terminal side, received data
  output logic                                  term_valid_o,
  output logic [rrec_pkg::RREC_DATA_W-1:0]      term_data_o,
  // terminal side, data to send
  input  wire logic                             tx_valid_i,
  input  wire logic                             tx_last_i,
  input  wire logic [rrec_pkg::RREC_DATA_W-1:0] tx_data_i,
  output logic                                  tx_ready_o,
  output logic                                  tx_code_valid_o,
  output logic                                  tx_code_last_o,
  output logic [rrec_pkg::RREC_CODE_W-1:0]      tx_code_o
);
  import rrec_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int SW = $clog2(SUB_WORDS + 1);
  localparam logic [SW-1:0] SUB_LAST = SW'(SUB_WORDS - 1);
  localparam logic [SW-1:0] SUB_FULL = SW'(SUB_WORDS);
  localparam logic [AW:0]   ROOM     = (AW+1)'(DEPTH - 4);

  // crc over one data word
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ RREC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // hamming encode: parity at positions 1,2,4,8,16
  function automatic logic [RREC_CODE_W-1:0] fec_enc(input logic [15:0] d);
    logic [RREC_CODE_W-1:0] c;
    int                     k;
    c = '0;
    k = 0;
    for (int p = 1; p <= RREC_CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 5; b++) begin
      for (int p = 1; p <= RREC_CODE_W; p++) begin
        if (((p >> b) & 1) == 1 && p != (1 << b)) c[(1<<b)-1] ^= c[p-1];
      end
    end
    return c;
  endfunction

  // syndrome of a received code word
  function automatic logic [4:0] fec_syn(input logic [RREC_CODE_W-1:0] c);
    logic [4:0] s;
    s = '0;
    for (int p = 1; p <= RREC_CODE_W; p++) begin
      if (c[p-1]) s ^= 5'(p);
    end
    return s;
  endfunction

  // correct the flagged position and pull the data bits out
  function automatic logic [15:0] fec_dec(input logic [RREC_CODE_W-1:0] c,
                                          input logic [4:0] s);
    logic [RREC_CODE_W-1:0] f;
    logic [15:0]            d;
    int                     k;
    f = c;
    d = '0;
    k = 0;
    if (s != 5'h00 && s <= 5'(RREC_CODE_W)) f[s-1] = ~f[s-1];
    for (int p = 1; p <= RREC_CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = f[p-1];
        k++;
      end
    end
    return d;
  endfunction

  // configuration and status registers
  logic [1:0]          mode_q;       // check mode
  logic                fec_q;        // forward correction on
  logic                div_q;        // second receiver fitted and in use
  logic [7:0]          thresh_q;     // search threshold, signed dbm
  logic [RREC_ST_W-1:0] stat_q;      // sticky events
  logic [RREC_ST_W-1:0] mask_q;      // interrupt enables
  logic [RREC_ST_W-1:0] ev_set;      // events this cycle

  // apb access phase, answered one cycle after it starts
  logic acc;
  logic wr_hit;
  assign acc    = psel_i & penable_i & ~pready_o;
  assign wr_hit = psel_i & penable_i & pready_o & pwrite_i;

  // strength state
  logic [7:0]  meas_a_q, meas_b_q;   // live strength per receiver
  logic [7:0]  rec_a_q, rec_b_q;     // strength held from last message
  logic [31:0] hold_q;               // hold countdown
  logic [7:0]  best_live;            // stronger live receiver
  logic [7:0]  best_rec;             // stronger held value
  logic        b_wins;               // second receiver stronger

  // receive path
  logic [RREC_DATA_W-1:0] buf_q [DEPTH];  // message and sub-frame store
  logic [AW:0]   wr_q, ok_q, rd_q;        // write, verified, read pointers
  logic [SW-1:0] sub_q;                   // words in current sub-frame
  logic [15:0]   rcrc_q;                  // running receive checksum
  logic          drop_q;                  // rest of message is discarded
  logic          take;
  logic [4:0]    syn;
  logic [15:0]   rdat;
  logic          is_ck;
  logic          good;
  logic [AW:0]   used;

  // transmit path
  rrec_tx_t      tx_st_q;
  logic [SW-1:0] tsub_q;
  logic [15:0]   tcrc_q;
  logic          tlast_q;
  logic          tx_take;

  // registers written by software
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q   <= RREC_RST_MODE;
      fec_q    <= RREC_RST_FEC;
      div_q    <= RREC_RST_DIV;
      thresh_q <= RREC_RST_THRESH;
      mask_q   <= RREC_RST_MASK;
    end else if (wr_hit) begin
      unique case (paddr_i)
        RREC_OFF_CTRL: begin
          mode_q <= pwdata_i[RREC_CTRL_MODE_LSB +: 2];
          fec_q  <= pwdata_i[RREC_CTRL_FEC];
          div_q  <= pwdata_i[RREC_CTRL_DIV];
        end
        RREC_OFF_THRESH: thresh_q <= pwdata_i[7:0];
        RREC_OFF_MASK:   mask_q   <= pwdata_i[RREC_ST_W-1:0];
        default: ;                               // read-only or unmapped
      endcase
    end
  end

  // sticky status; a new event beats a same-cycle clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else if (wr_hit && paddr_i == RREC_OFF_STAT) begin
      stat_q <= (stat_q & ~pwdata_i[RREC_ST_W-1:0]) | ev_set;
    end else begin
      stat_q <= stat_q | ev_set;
    end
  end

  // interrupt level, registered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else       irq_o <= |(stat_q & mask_q);
  end

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= acc;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      if (acc) begin
        unique case (paddr_i)
          RREC_OFF_CTRL:   prdata_o <= {28'h000_0000, div_q, fec_q, mode_q};
          RREC_OFF_THRESH: prdata_o <= {24'h00_0000, thresh_q};
          RREC_OFF_RSSI:   prdata_o <= {24'h00_0000, best_rec};
          RREC_OFF_STAT:   prdata_o <= {27'h000_0000, stat_q};
          RREC_OFF_MASK:   prdata_o <= {27'h000_0000, mask_q};
          RREC_OFF_LIVE:   prdata_o <= {22'h00_0000, search_en_o, rx_sel_o, best_live};
          default:         pslverr_o <= 1'b1;    // unmapped reads zero, error
        endcase
      end
    end
  end

  // strength comparisons, signed dbm
  assign b_wins    = div_q && ($signed(meas_b_q) > $signed(meas_a_q));
  assign best_live = b_wins ? meas_b_q : meas_a_q;
  assign best_rec  = (div_q && $signed(rec_b_q) > $signed(rec_a_q)) ? rec_b_q : rec_a_q;

  // live strength, refreshed every cycle of the receive state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meas_a_q <= 8'h80;
      meas_b_q <= 8'h80;
    end else if (rx_state_i) begin
      meas_a_q <= rssi_a_i;
      meas_b_q <= rssi_b_i;
    end
  end

  // search gate and receiver choice
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      search_en_o <= 1'b0;
      rx_sel_o    <= 1'b0;
    end else begin
      search_en_o <= rx_state_i && ($signed(best_live) > $signed(thresh_q));
      rx_sel_o    <= b_wins;
    end
  end

  // held strength: caught at message end, zeroed when the hold runs out
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rec_a_q <= '0;
      rec_b_q <= '0;
      hold_q  <= '0;
    end else if (take && rx_last_i) begin
      rec_a_q <= meas_a_q;
      rec_b_q <= div_q ? meas_b_q : 8'h80;
      hold_q  <= 32'(HOLD_CYC);
    end else if (hold_q == 32'h0000_0001) begin
      rec_a_q <= '0;
      rec_b_q <= '0;
      hold_q  <= '0;
    end else if (hold_q != '0) begin
      hold_q <= hold_q - 32'h0000_0001;
    end
  end

  // receive word decode
  assign take  = rx_valid_i & rx_ready_o;
  assign syn   = fec_q ? fec_syn(rx_code_i) : 5'h00;
  assign rdat  = fec_q ? fec_dec(rx_code_i, syn) : rx_code_i[15:0];
  assign is_ck = (sub_q == SUB_FULL) || rx_last_i;
  assign good  = (rdat == rcrc_q);
  assign used  = wr_q - rd_q;

  // event sources
  always_comb begin
    ev_set = '0;
    ev_set[RREC_ST_FIX] = take && syn != 5'h00;
    ev_set[RREC_ST_EXP] = hold_q == 32'h0000_0001;
    ev_set[RREC_ST_ERR] = take && is_ck && !good && mode_q != RREC_CHK_NONE;
    ev_set[RREC_ST_OK]  = take && rx_last_i && !drop_q && (good || mode_q == RREC_CHK_NONE);
    ev_set[RREC_ST_OVF] = take && !is_ck && !drop_q && mode_q[1] && used >= ROOM;
  end

  // buffer write; checksum words are never stored
  always_ff @(posedge ref_clk_i) begin
    if (take && !is_ck && !drop_q) buf_q[wr_q[AW-1:0]] <= rdat;
  end

  // receive checker: pointers, sub-frame count, discard state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_q   <= '0;
      ok_q   <= '0;
      sub_q  <= '0;
      rcrc_q <= RREC_CRC_INIT;
      drop_q <= 1'b0;
    end else if (take) begin
      if (!is_ck) begin
        sub_q  <= sub_q + SW'(1);
        rcrc_q <= crc_word(rcrc_q, rdat);
        if (mode_q[1] && !drop_q && used >= ROOM) begin
          drop_q <= 1'b1;                        // full mode cannot fit it
          wr_q   <= ok_q;
        end else if (!drop_q) begin
          wr_q <= wr_q + 1'b1;
          if (mode_q == RREC_CHK_NONE) ok_q <= wr_q + 1'b1;
        end
      end else begin
        sub_q  <= '0;
        rcrc_q <= RREC_CRC_INIT;
        unique case (mode_q)
          RREC_CHK_NONE: ;
          RREC_CHK_PART: begin
            if (good && !drop_q) begin
              ok_q <= wr_q;
            end else begin
              wr_q   <= ok_q;
              drop_q <= 1'b1;
            end
          end
          default: begin
            if (!good) drop_q <= 1'b1;
            if (rx_last_i) begin
              if (good && !drop_q) ok_q <= wr_q;
              else                 wr_q <= ok_q;
            end
          end
        endcase
        if (rx_last_i) drop_q <= 1'b0;           // next message starts clean
      end
    end
  end

  // receive flow: full mode never stalls, it drops on overflow instead
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) rx_ready_o <= 1'b0;
    else       rx_ready_o <= mode_q[1] || (used < ROOM);
  end

  // drain released words to the terminal; no-check mode releases each word unverified
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_q         <= '0;
      term_valid_o <= 1'b0;
      term_data_o  <= '0;
    end else if (rd_q != ok_q) begin
      term_valid_o <= 1'b1;
      term_data_o  <= buf_q[rd_q[AW-1:0]];
      rd_q         <= rd_q + 1'b1;
    end else begin
      term_valid_o <= 1'b0;
    end
  end

  // transmit sequencer: data words, then a checksum word per sub-frame
  assign tx_take = tx_valid_i & tx_ready_o;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_st_q         <= RREC_TX_DATA;
      tsub_q          <= '0;
      tcrc_q          <= RREC_CRC_INIT;
      tlast_q         <= 1'b0;
      tx_ready_o      <= 1'b0;
      tx_code_valid_o <= 1'b0;
      tx_code_last_o  <= 1'b0;
      tx_code_o       <= '0;
    end else begin
      tx_code_valid_o <= 1'b0;
      tx_code_last_o  <= 1'b0;
      unique case (tx_st_q)
        RREC_TX_DATA: begin
          tx_ready_o <= 1'b1;
          if (tx_take) begin
            tx_code_valid_o <= 1'b1;
            tx_code_o <= fec_q ? fec_enc(tx_data_i)
                               : {5'h00, tx_data_i};
            tcrc_q    <= crc_word(tcrc_q, tx_data_i);
            tsub_q    <= tsub_q + SW'(1);
            tlast_q   <= tx_last_i;
            if (tsub_q == SUB_LAST || tx_last_i) begin
              tx_st_q    <= RREC_TX_CK;
              tx_ready_o <= 1'b0;
            end
          end
        end
        RREC_TX_CK: begin
          tx_code_valid_o <= 1'b1;
          tx_code_last_o  <= tlast_q;
          tx_code_o <= fec_q ? fec_enc(tcrc_q) : {5'h00, tcrc_q};
          tcrc_q     <= RREC_CRC_INIT;
          tsub_q     <= '0;
          tx_st_q    <= RREC_TX_DATA;
          tx_ready_o <= 1'b1;
        end
      endcase
    end
  end

endmodule

// [rrec_remote.sv]
// Purpose: remote radio modem model feeding coded messages to the receiver
// Assumes: fec set means hamming words with one data bit flipped
// Notes:   a checksum word closes each sub-frame; the last one carries last_o
`timescale 1ns/1ns
module rrec_remote (
  input  wire logic                        clk_i,
  input  wire logic                        ready_i,
  output logic                             valid_o,
  output logic                             last_o,
  output logic [rrec_pkg::RREC_CODE_W-1:0] code_o,
  output logic                             hung_o
);
  import rrec_pkg::*;
  logic fec = 1'b0;
  // quiet line at time zero
  initial begin
    valid_o = 1'b0;
    last_o  = 1'b0;
    code_o  = 21'h00_0000;
    hung_o  = 1'b0;
  end
  // checksum over one word, msb first
  function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? RREC_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  // hamming word
  function automatic logic [20:0] enc(input logic [15:0] d);
    logic [20:0] c;
    logic [4:0]  s = 5'h00;
    c = {d[15:11], 1'b0, d[10:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
    for (int p = 1; p <= 21; p++) s ^= c[p-1] ? 5'(p) : 5'h00;
    for (int b = 0; b < 5; b++) c[(1<<b)-1] = s[b];
    return c;
  endfunction
  // one word, held until the device is seen ready at an edge
  task automatic put(input logic [15:0] w, input logic l);
    int n;
    valid_o <= 1'b1;
    last_o  <= l;
    code_o  <= fec ? enc(w) ^ 21'h00_0400 : {5'h00, w};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ready_i !== 1'b1 && n < 200);
    if (n >= 200) begin
      hung_o <= 1'b1;
    end
  endtask
  // words a000 upward; sub-frame bad gets a broken checksum
  task automatic send(input int len, input int bad, input int sub);
    logic [15:0] c;
    int          s;
    c = RREC_CRC_INIT;
    s = 0;
    for (int i = 0; i < len; i++) begin
      put(16'hA000 + 16'(i), 1'b0);
      c = crc_w(c, 16'hA000 + 16'(i));
      if ((i + 1) % sub == 0 || i + 1 == len) begin
        put(c ^ {15'h0000, s == bad}, i + 1 == len);
        c = RREC_CRC_INIT;
        s++;
      end
    end
    valid_o <= 1'b0;
    code_o  <= ~code_o;  // released line must not keep its last value
  endtask
endmodule

// [rrec_chk_sva.sv]
// Purpose: port checks of the receive error check block
// Assumes: one clock, synchronous active-high reset
// Notes:   mode and diversity shadowed from ctrl writes
`timescale 1ns/1ns
module rrec_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        rx_state_i,
  input wire logic [7:0]  rssi_a_i,
  input wire logic [7:0]  rssi_b_i,
  input wire logic        search_en_o,
  input wire logic        rx_sel_o,
  input wire logic        rx_valid_i,
  input wire logic        rx_last_i,
  input wire logic        rx_ready_o,
  input wire logic        term_valid_o,
  input wire logic        tx_valid_i,
  input wire logic        tx_ready_o,
  input wire logic        tx_code_valid_o
);
  import rrec_pkg::*;
  logic [1:0] mode_q;    // shadow check mode
  logic       div_q;     // shadow diversity
  logic       in_msg_q;  // message words still arriving
  logic       wr_ctrl;   // ctrl write lands this edge
  assign wr_ctrl = psel_i && penable_i && pready_o && pwrite_i && paddr_i == RREC_OFF_CTRL;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // shadow updates on the same edge as the register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= RREC_RST_MODE;
      div_q  <= RREC_RST_DIV;
    end else if (wr_ctrl) begin
      mode_q <= pwdata_i[RREC_CTRL_MODE_LSB +: 2];
      div_q  <= pwdata_i[RREC_CTRL_DIV];
    end
  end
  // open from first taken word until the last one
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      in_msg_q <= 1'b0;
    end else if (rx_valid_i && rx_ready_o) begin
      in_msg_q <= !rx_last_i;
    end
  end
  a_apb_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb access not answered");
  a_apb_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held over one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("slave error without ready");
  a_search_gate: assert property (!rx_state_i [*3] |-> !search_en_o)
    else $error("search outside receive state");
  a_div_off: assert property (!div_q [*3] |-> !rx_sel_o)
    else $error("second receiver picked with diversity off");
  a_div_pick: assert property (($signed(rssi_b_i) > $signed(rssi_a_i) && div_q) [*3] |-> rx_sel_o)
    else $error("stronger receiver not picked");
  a_full_hold: assert property (mode_q[1] && in_msg_q |-> !term_valid_o)
    else $error("full mode forwarded before message end");
  a_tx_answer: assert property (tx_valid_i && tx_ready_o |=> tx_code_valid_o)
    else $error("sent word not coded next cycle");
endmodule
bind rrec_top rrec_chk chk_u (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pready_o, .pslverr_o, .rx_state_i, .rssi_a_i, .rssi_b_i, .search_en_o,
  .rx_sel_o, .rx_valid_i, .rx_last_i, .rx_ready_o, .term_valid_o, .tx_valid_i,
  .tx_ready_o, .tx_code_valid_o);

// [tb.sv]
// Purpose: self-checking bench of the receive error check block
// Assumes: strength hold shortened to 50 cycles
// Notes:   remote modem model feeds the radio side
`timescale 1ns/1ns
module tb;
  import rrec_pkg::*;
  localparam int HOLD = 50;  // short hold keeps the run brief
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic        rx_state_i = 1'b0;
  logic [7:0]  rssi_a_i = 8'h80;  // weakest reading
  logic [7:0]  rssi_b_i = 8'h80;
  logic        tx_valid_i = 1'b0;
  logic        tx_last_i = 1'b0;
  logic [15:0] tx_data_i = 16'h0000;
  logic        pready_o, pslverr_o, irq_o, search_en_o, rx_sel_o, rx_ready_o, hung;
  logic        term_valid_o, tx_ready_o, tx_code_valid_o, tx_code_last_o, rx_valid_i, rx_last_i;
  logic [31:0] prdata_o, rdat;
  logic [20:0] rx_code_i, tx_code_o;
  logic [15:0] term_data_o;
  logic        perr;      // slave error of last transfer
  logic [15:0] got_q[$];  // words handed to the terminal
  logic [21:0] txo_q[$];  // coded words sent, with last flag
  int          fails = 0;
  int          checked = 0;
  rrec_top #(.HOLD_CYC(HOLD)) dut_u (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .irq_o, .rx_state_i, .rssi_a_i,
    .rssi_b_i, .search_en_o, .rx_sel_o, .rx_valid_i, .rx_last_i, .rx_code_i, .rx_ready_o,
    .term_valid_o, .term_data_o, .tx_valid_i, .tx_last_i, .tx_data_i, .tx_ready_o,
    .tx_code_valid_o, .tx_code_last_o, .tx_code_o);
  rrec_remote pm_u (.clk_i(ref_clk_i), .ready_i(rx_ready_o), .valid_o(rx_valid_i),
    .last_o(rx_last_i), .code_o(rx_code_i), .hung_o(hung));
  always #20 ref_clk_i = ~ref_clk_i;
  // record words leaving in both directions
  always @(posedge ref_clk_i) begin
    if (term_valid_o === 1'b1) got_q.push_back(term_data_o);
    if (tx_code_valid_o === 1'b1) txo_q.push_back({tx_code_last_o, tx_code_o});
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // bounded wait for pready (0) or tx_ready (1) seen high
  task automatic hold_on(input bit sel);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while ((sel ? tx_ready_o : pready_o) !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      close_out();
    end
  endtask
  // one apb transfer, then an idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    hold_on(1'b0);
    rdat = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rdat & m, e);
  endtask
  // terminal got words a000 upward, n of them
  task automatic chk_rx(input int n);
    repeat (30) @(posedge ref_clk_i);
    cmp(32'(got_q.size()), 32'(n));
    cmp(32'(hung), 32'h0000_0000);
    foreach (got_q[i]) cmp(32'(got_q[i]), 32'h0000_A000 + 32'(i));
    got_q.delete();
  endtask
  task automatic t_reset;
    rd(RREC_OFF_CTRL, 32'h0000_0000, 32'h0000_000F);
    rd(RREC_OFF_THRESH, {24'h00_0000, RREC_RST_THRESH}, 32'h0000_00FF);
    rd(RREC_OFF_STAT, 32'h0000_0000, 32'h0000_001F);
    rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    cmp(32'(perr), 32'h0000_0001);
    apb(1'b1, RREC_OFF_RSSI, 32'h0000_00FF);
    rd(RREC_OFF_RSSI, 32'h0000_0000, 32'hFFFF_FFFF);
    cmp(32'(search_en_o), 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_rssi;
    rx_state_i <= 1'b1;
    rssi_a_i <= 8'hC4;  // -60 dbm
    rssi_b_i <= 8'hCE;  // -50 dbm
    repeat (4) @(posedge ref_clk_i);
    cmp(32'(search_en_o), 32'h0000_0001);
    apb(1'b1, RREC_OFF_THRESH, 32'h0000_00D8);
    repeat (4) @(posedge ref_clk_i);
    cmp(32'(search_en_o), 32'h0000_0000);
    apb(1'b1, RREC_OFF_THRESH, 32'h0000_0092);
    apb(1'b1, RREC_OFF_CTRL, 32'h0000_0008);
    repeat (4) @(posedge ref_clk_i);
    cmp(32'(rx_sel_o), 32'h0000_0001);
    pm_u.send(2, 9, 4);
    chk_rx(2);
    rd(RREC_OFF_RSSI, 32'h0000_00CE, 32'h0000_00FF);
    apb(1'b1, RREC_OFF_CTRL, 32'h0000_0000);
    pm_u.send(2, 9, 4);
    chk_rx(2);
    rd(RREC_OFF_RSSI, 32'h0000_00C4, 32'h0000_00FF);
    repeat (HOLD) @(posedge ref_clk_i);
    rd(RREC_OFF_RSSI, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(RREC_OFF_STAT, 32'h0000_0008, 32'h0000_0008);
    $display("strength test done");
  endtask
  task automatic t_modes;
    pm_u.send(6, 0, 4);
    chk_rx(6);
    rd(RREC_OFF_STAT, 32'h0000_0000, 32'h0000_0002);
    apb(1'b1, RREC_OFF_CTRL, 32'h0000_0001);
    pm_u.send(10, 9, 4);
    chk_rx(10);
    pm_u.send(10, 1, 4);
    chk_rx(4);
    rd(RREC_OFF_STAT, 32'h0000_0002, 32'h0000_0002);
    cmp(32'(irq_o), 32'h0000_0000);
    apb(1'b1, RREC_OFF_MASK, 32'h0000_0002);
    repeat (3) @(posedge ref_clk_i);
    cmp(32'(irq_o), 32'h0000_0001);
    apb(1'b1, RREC_OFF_STAT, 32'h0000_0002);
    repeat (3) @(posedge ref_clk_i);
    cmp(32'(irq_o), 32'h0000_0000);
    apb(1'b1, RREC_OFF_CTRL, 32'h0000_0002);
    pm_u.send(6, 9, 4);
    chk_rx(6);
    pm_u.send(10, 2, 4);
    chk_rx(0);
    $display("mode test done");
  endtask
  // fec on: five words received with a bit hit, five sent
  task automatic t_tx;
    logic [15:0] c;
    logic [21:0] e[$];
    c = RREC_CRC_INIT;
    apb(1'b1, RREC_OFF_CTRL, 32'h0000_0004);
    pm_u.fec = 1'b1;
    pm_u.send(5, 9, 4);
    chk_rx(5);
    for (int i = 0; i < 5; i++) begin
      tx_valid_i <= 1'b1;
      tx_last_i <= (i == 4);
      tx_data_i <= 16'hB000 + 16'(i);
      hold_on(1'b1);
      e.push_back({1'b0, pm_u.enc(16'hB000 + 16'(i))});
      c = pm_u.crc_w(c, 16'hB000 + 16'(i));
      if (i >= 3) begin
        e.push_back({i == 4, pm_u.enc(c)});
        c = RREC_CRC_INIT;
      end
    end
    tx_valid_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    cmp(32'(txo_q.size()), 32'h0000_0007);
    foreach (e[i]) cmp(32'(txo_q[i]), 32'(e[i]));
    $display("send test done");
  endtask
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset();
    t_rssi();
    t_modes();
    t_tx();
    close_out();
  end
endmodule
